// >>> rtl/prc_defines.svh
// Purpose: constants for the reference path control block
// Assumes: APB word addressing, register index = byte address / 4
// Notes:   fields are taken from the active copy after an update write
`ifndef PRC_DEFINES_SVH
`define PRC_DEFINES_SVH

`define PRC_IDX_BASE    10'h010
`define PRC_IDX_LAST    10'h020
`define PRC_IDX_STAT    10'h021
`define PRC_IDX_UPD     10'h232
`define PRC_NREG        17
`define PRC_OFF_PUMP    5'd0
`define PRC_OFF_RLO     5'd1
`define PRC_OFF_RHI     5'd2
`define PRC_OFF_ACNT    5'd3
`define PRC_OFF_BLO     5'd4
`define PRC_OFF_BHI     5'd5
`define PRC_OFF_PRE     5'd6
`define PRC_OFF_CAL     5'd8
`define PRC_OFF_SYNC    5'd9
`define PRC_OFF_MON     5'd11
`define PRC_OFF_REFC    5'd12
`define PRC_OFF_DIFF    5'd13
`define PRC_OFF_CUR     5'd16
`define PRC_RST_PUMP    8'h01
`define PRC_LOOP_ON     2'h0
`define PRC_CP_HIZ      3'h0
`define PRC_CP_UP       3'h1
`define PRC_CP_DOWN     3'h2
`define PRC_CP_NORMAL   3'h3
`define PRC_MON_P_BAD   4'h7
`define PRC_MON_S_BAD   4'h8
`define PRC_STAT_SWITCH 4'hf
`define PRC_MON_TIMEOUT 12'd1024
`define PRC_UPD_BIT     0
`define PRC_NSYNC       5

`endif

// >>> rtl/prc_pkg.sv
// Purpose: shared types for the reference path control block
// Assumes: nothing beyond the defines header
// Notes:   deglitch gate states
package prc_pkg;
   typedef enum logic {PRC_DG_PASS, PRC_DG_WAIT} prc_dg_t;
endpackage : prc_pkg

// >>> rtl/prc_top.sv
// Purpose: PLL reference path control: selection, switchover, dividers, pump
// Assumes: reference and feedback pins are slow against sys_clk_i
// Notes:   settings written over APB apply only after the update write
//
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "prc_defines.svh"
module prc_top
   import prc_pkg::*;
(
   input  wire logic        sys_clk_i,
   input  wire logic        rst_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic        primary_reference_i,
   input  wire logic        secondary_reference_i,
   input  wire logic        vco_feedback_i,
   input  wire logic        reference_choice_pin_i,
   input  wire logic        sync_n_i,
   output logic             pump_up_o,
   output logic             pump_down_o,
   output logic             pump_hiz_o,
   output logic      [2:0]  pump_current_o,
   output logic             diff_rx_power_o,
   output logic             primary_buf_power_o,
   output logic             secondary_buf_power_o,
   output logic             reference_monitor_pin_o,
   output logic             status_pin_o,
   output logic             secondary_active_o,
   output logic             pfd_ref_o,
   output logic             pfd_fb_o,
   output logic             vco_cal_o
);

   // ---------------- pin synchronisers ----------------
   logic [`PRC_NSYNC-1:0] pin_vec;
   logic [`PRC_NSYNC-1:0] lvl;
   logic [`PRC_NSYNC-1:0] rise;
   logic [2:0]            sync_q [`PRC_NSYNC];

   assign pin_vec = {sync_n_i, reference_choice_pin_i, vco_feedback_i,
                     secondary_reference_i, primary_reference_i};

   genvar g;
   generate
      for (g = 0; g < `PRC_NSYNC; g++) begin : g_sync
         always_ff @(posedge sys_clk_i) begin
            if (rst_i) begin
               sync_q[g] <= 3'h0;
               lvl[g]    <= 1'b0;
            end else begin
               sync_q[g] <= {sync_q[g][1:0], pin_vec[g]};
               if (sync_q[g][2] == sync_q[g][1])
                  lvl[g] <= sync_q[g][1];
            end
         end
         assign rise[g] = (sync_q[g][2] == sync_q[g][1]) & sync_q[g][1] & ~lvl[g];
      end
   endgenerate

   // ---------------- register file ----------------
   logic [7:0] shadow [`PRC_NREG];
   logic [7:0] active [`PRC_NREG];
   logic [9:0] idx;
   logic [4:0] off;
   logic       acc_start;
   logic       wr_fire;
   logic [7:0] status_byte;

   function automatic logic idx_in_file(input logic [9:0] i);
      return (i >= `PRC_IDX_BASE) && (i <= `PRC_IDX_LAST);
   endfunction : idx_in_file

   assign idx       = paddr_i[11:2];
   assign off       = 5'(idx - `PRC_IDX_BASE);
   assign acc_start = psel_i & penable_i & ~pready_o;
   assign wr_fire   = psel_i & penable_i & pready_o & pwrite_i;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o  <= 32'h0;
      end else begin
         pready_o <= acc_start;
         if (acc_start) begin
            prdata_o  <= 32'h0;
            pslverr_o <= 1'b0;
            if (idx_in_file(idx))
               prdata_o <= {24'h0, shadow[off]};
            else if (idx == `PRC_IDX_STAT)
               prdata_o <= {24'h0, status_byte};
            else if (idx != `PRC_IDX_UPD)
               pslverr_o <= 1'b1;
         end
      end
   end

   // zero resets, with the pump register at 01 (loop off), keep every reference input off
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `PRC_NREG; i++) begin
            shadow[i] <= 8'h0;
            active[i] <= 8'h0;
         end
         shadow[`PRC_OFF_PUMP] <= `PRC_RST_PUMP;
         active[`PRC_OFF_PUMP] <= `PRC_RST_PUMP;
      end else begin
         if (wr_fire && idx_in_file(idx))
            shadow[off] <= pwdata_i[7:0];
         if (wr_fire && (idx == `PRC_IDX_UPD) && pwdata_i[`PRC_UPD_BIT])
            for (int i = 0; i < `PRC_NREG; i++)
               active[i] <= shadow[i];
      end
   end

   // ---------------- fields ----------------
   logic        loop_on;
   logic [2:0]  pump_mode;
   logic        pol_neg;
   logic [13:0] r_val;
   logic [5:0]  a_val;
   logic [12:0] b_val;
   logic [2:0]  p_sel;
   logic        r_own_rst;
   logic        ab_rst;
   logic        shared_rst;
   logic        sync_en;
   logic [3:0]  mon_src;
   logic [3:0]  stat_src;
   logic        diff_sel;
   logic        p_en;
   logic        s_en;
   logic        auto_en;
   logic        prefer_sec;
   logic        use_pin;
   logic        man_sel;
   logic        dg_off;
   logic        diff_en;

   assign loop_on    = active[`PRC_OFF_PUMP][1:0] == `PRC_LOOP_ON;
   assign pump_mode  = active[`PRC_OFF_PUMP][6:4];
   assign pol_neg    = active[`PRC_OFF_PUMP][7];
   assign r_val      = {active[`PRC_OFF_RHI][5:0], active[`PRC_OFF_RLO]};
   assign a_val      = active[`PRC_OFF_ACNT][5:0];
   assign b_val      = {active[`PRC_OFF_BHI][4:0], active[`PRC_OFF_BLO]};
   assign p_sel      = active[`PRC_OFF_PRE][2:0];
   assign r_own_rst  = active[`PRC_OFF_PRE][4];
   assign ab_rst     = active[`PRC_OFF_PRE][5];
   assign shared_rst = active[`PRC_OFF_PRE][6];
   assign sync_en    = active[`PRC_OFF_SYNC][7];
   assign mon_src    = active[`PRC_OFF_MON][3:0];
   assign stat_src   = active[`PRC_OFF_MON][7:4];
   assign diff_sel   = active[`PRC_OFF_REFC][0];
   assign p_en       = active[`PRC_OFF_REFC][1];
   assign s_en       = active[`PRC_OFF_REFC][2];
   assign auto_en    = active[`PRC_OFF_REFC][3];
   assign prefer_sec = active[`PRC_OFF_REFC][4];
   assign use_pin    = active[`PRC_OFF_REFC][5];
   assign man_sel    = active[`PRC_OFF_REFC][6];
   assign dg_off     = active[`PRC_OFF_REFC][7];
   assign diff_en    = active[`PRC_OFF_DIFF][0];

   // ---------------- front end power ----------------
   logic diff_pwr;
   logic p_pwr;
   logic s_pwr;

   assign diff_pwr = loop_on & diff_sel & diff_en;
   assign p_pwr    = loop_on & ~diff_sel & p_en;
   assign s_pwr    = loop_on & ~diff_sel & s_en;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         diff_rx_power_o       <= 1'b0;
         primary_buf_power_o   <= 1'b0;
         secondary_buf_power_o <= 1'b0;
         vco_cal_o             <= 1'b0;
         pump_current_o        <= 3'h0;
      end else begin
         diff_rx_power_o       <= diff_pwr;
         primary_buf_power_o   <= p_pwr;
         secondary_buf_power_o <= s_pwr;
         // calibration output follows the calibration register bit, with no gating
         vco_cal_o             <= active[`PRC_OFF_CAL][0];
         // step k gives (k+1)/8 of full scale
         pump_current_o        <= active[`PRC_OFF_CUR][2:0];
      end
   end

   // ---------------- reference watchdogs ----------------
   logic [1:0]  ref_rise;
   logic [1:0]  ref_valid;
   logic [11:0] miss_cnt [2];

   assign ref_rise = {rise[1] & s_pwr, rise[0] & p_pwr};

   generate
      for (g = 0; g < 2; g++) begin : g_mon
         always_ff @(posedge sys_clk_i) begin
            if (rst_i || !ref_rise[g] && (miss_cnt[g] == `PRC_MON_TIMEOUT)) begin
               miss_cnt[g]  <= 12'h0;
               ref_valid[g] <= 1'b0;
            end else if (ref_rise[g]) begin
               miss_cnt[g]  <= 12'h0;
               ref_valid[g] <= 1'b1;
            end else if (ref_valid[g]) begin
               miss_cnt[g]  <= miss_cnt[g] + 12'd1;
            end
         end
      end
   endgenerate

   // ---------------- selection and deglitch ----------------
   logic    next_sel;
   logic    sel_q;
   logic    sel_chg;
   logic    cur_rise;
   logic    gated;
   prc_dg_t dg_state;

   always_comb begin
      next_sel = 1'b0;
      if (!diff_sel) begin
         if (auto_en) begin
            // revertive only: the preferred input wins once it is valid
            if (prefer_sec)
               next_sel = ~(~ref_valid[1] & ref_valid[0]);
            else
               next_sel = ~ref_valid[0] & ref_valid[1];
         end else begin
            next_sel = use_pin ? lvl[3] : man_sel;
         end
      end
   end

   assign sel_chg  = next_sel != sel_q;
   assign cur_rise = diff_sel ? (rise[0] & diff_pwr) : (sel_q ? ref_rise[1] : ref_rise[0]);
   assign gated    = cur_rise & (dg_state == PRC_DG_PASS) & ~sel_chg;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         sel_q    <= 1'b0;
         dg_state <= PRC_DG_PASS;
      end else begin
         sel_q <= next_sel;
         case (dg_state)
            PRC_DG_PASS: begin
               if (sel_chg && !dg_off)
                  dg_state <= PRC_DG_WAIT;
            end
            PRC_DG_WAIT: begin
               // first edge of the new input only aligns; with no clock it waits
               if (dg_off || cur_rise && !sel_chg)
                  dg_state <= PRC_DG_PASS;
            end
            default: dg_state <= PRC_DG_PASS;
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         reference_monitor_pin_o <= 1'b0;
         status_pin_o            <= 1'b0;
         secondary_active_o      <= 1'b0;
      end else begin
         reference_monitor_pin_o <= (mon_src == `PRC_MON_P_BAD) ? ~ref_valid[0] :
                                    (mon_src == `PRC_MON_S_BAD) ? ~ref_valid[1] : 1'b0;
         status_pin_o            <= (stat_src == `PRC_STAT_SWITCH) && sel_q;
         secondary_active_o      <= sel_q;
      end
   end

   // ---------------- dividers ----------------
   logic        sync_rst;
   logic        r_reset;
   logic        n_reset;
   logic [13:0] r_cnt;
   logic [13:0] r_term;
   logic [18:0] n_val;
   logic [18:0] n_term;
   logic [18:0] n_cnt;

   function automatic logic [5:0] p_mod(input logic [2:0] code);
      case (code)
         3'h0:    return 6'd2;
         3'h1:    return 6'd4;
         3'h2:    return 6'd8;
         3'h3:    return 6'd16;
         default: return 6'd32;
      endcase
   endfunction : p_mod

   assign sync_rst = sync_en & ~lvl[4];
   assign r_reset  = r_own_rst | shared_rst | sync_rst;
   assign n_reset  = ab_rst | shared_rst | sync_rst;
   assign r_term   = (r_val < 14'd2) ? 14'h0 : r_val - 14'd1;
   // swallow count below main count is the programmer's duty
   assign n_val    = 19'(19'(p_mod(p_sel)) * 19'(b_val)) + 19'(a_val);
   assign n_term   = (n_val < 19'd2) ? 19'h0 : n_val - 19'd1;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || r_reset) begin
         r_cnt     <= 14'h0;
         pfd_ref_o <= 1'b0;
      end else begin
         pfd_ref_o <= 1'b0;
         if (gated) begin
            if (r_cnt >= r_term) begin
               r_cnt     <= 14'h0;
               pfd_ref_o <= 1'b1;
            end else begin
               r_cnt <= r_cnt + 14'd1;
            end
         end
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || n_reset) begin
         n_cnt    <= 19'h0;
         pfd_fb_o <= 1'b0;
      end else begin
         pfd_fb_o <= 1'b0;
         if (rise[2] && loop_on) begin
            if (n_cnt >= n_term) begin
               n_cnt    <= 19'h0;
               pfd_fb_o <= 1'b1;
            end else begin
               n_cnt <= n_cnt + 19'd1;
            end
         end
      end
   end

   // ---------------- phase detector and pump ----------------
   logic pd_up;
   logic pd_dn;
   logic next_up;
   logic next_dn;

   always_ff @(posedge sys_clk_i) begin
      if (rst_i || !loop_on) begin
         pd_up <= 1'b0;
         pd_dn <= 1'b0;
      end else if ((pd_up | pfd_ref_o) & (pd_dn | pfd_fb_o)) begin
         pd_up <= 1'b0;
         pd_dn <= 1'b0;
      end else begin
         pd_up <= pd_up | pfd_ref_o;
         pd_dn <= pd_dn | pfd_fb_o;
      end
   end

   always_comb begin
      next_up = 1'b0;
      next_dn = 1'b0;
      if (loop_on) begin
         case (pump_mode)
            `PRC_CP_UP:     next_up = 1'b1;
            `PRC_CP_DOWN:   next_dn = 1'b1;
            `PRC_CP_NORMAL: begin
               next_up = pol_neg ? pd_dn : pd_up;
               next_dn = pol_neg ? pd_up : pd_dn;
            end
            default: begin
               next_up = 1'b0;
               next_dn = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         pump_up_o   <= 1'b0;
         pump_down_o <= 1'b0;
         pump_hiz_o  <= 1'b1;
      end else begin
         pump_up_o   <= next_up;
         pump_down_o <= next_dn;
         pump_hiz_o  <= ~next_up & ~next_dn;
      end
   end

   assign status_byte = {3'h0, dg_state == PRC_DG_WAIT, ref_valid, sel_q, loop_on};

   // ---------------- assertions ----------------
   sequence switch_seq;
      sel_chg && !dg_off;
   endsequence
   sequence blocked_seq;
      (dg_state == PRC_DG_WAIT) && !gated;
   endsequence

   pump_hiz_mode_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (pump_mode == `PRC_CP_HIZ) |=> pump_hiz_o && !pump_up_o && !pump_down_o)
      else $error("pump not idle in high impedance mode");
   forced_up_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (loop_on && pump_mode == `PRC_CP_UP) |=> pump_up_o && !pump_down_o)
      else $error("pump not forced up");
   diff_power_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!loop_on || !diff_sel) |=> !diff_rx_power_o)
      else $error("differential receiver powered when it must be off");
   se_power_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (diff_sel || !loop_on) |=> !primary_buf_power_o && !secondary_buf_power_o)
      else $error("single-ended buffer powered when it must be off");
   inputs_off_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (!p_en && !s_en && !diff_en) |=> !primary_buf_power_o && !secondary_buf_power_o
      && !diff_rx_power_o)
      else $error("reference input powered without enable");
   deglitch_gate_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      switch_seq |=> blocked_seq)
      else $error("edge passed right after a reference switch");
   revert_primary_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (auto_en && !prefer_sec && !diff_sel && ref_valid[0]) |-> ##2 !secondary_active_o)
      else $error("stayed on secondary with valid primary");
   monitor_pin_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (mon_src == `PRC_MON_P_BAD) |=> (reference_monitor_pin_o == !$past(ref_valid[0])))
      else $error("monitor pin does not follow primary validity");
   divide_one_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      (r_val < 14'd2 && gated && !r_reset) |=> pfd_ref_o)
      else $error("reference divider not dividing by one");
   r_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      r_reset |=> !pfd_ref_o && (r_cnt == 14'h0))
      else $error("reference divider active during reset");
   n_hold_a: assert property (@(posedge sys_clk_i) disable iff (rst_i)
      n_reset |=> !pfd_fb_o && (n_cnt == 19'h0))
      else $error("feedback divider active during reset");

endmodule : prc_top

// >>> sim/prc_ref_src.sv
// Purpose: reference and feedback clock sources at the block's pins
// Assumes: sources run free while enabled and stand low while stopped
// Notes:   periods are multiples of the sys_clk_i period; edges land on its falling edges
`timescale 1ns/1ps
module prc_ref_src (
   input  wire logic pri_en_i,
   input  wire logic sec_en_i,
   input  wire logic fb_en_i,
   output logic      primary_reference_o,
   output logic      secondary_reference_o,
   output logic      vco_feedback_o
);
   initial begin
      primary_reference_o = 1'b0;
      secondary_reference_o = 1'b0;
      vco_feedback_o = 1'b0;
   end
   // reference kept present unless a test stops it
   always #80 primary_reference_o = pri_en_i ? ~primary_reference_o : 1'b0;
   always #88 secondary_reference_o = sec_en_i ? ~secondary_reference_o : 1'b0;
   always #40 vco_feedback_o = fb_en_i ? ~vco_feedback_o : 1'b0;
endmodule : prc_ref_src

// >>> sim/prc_top_bench.sv
// Purpose: self-checking bench for the reference path control block
// Assumes: APB slave answers within a few cycles of penable
// Notes:   pulse counts allow one pulse of window phase error
`timescale 1ns/1ps
`include "prc_defines.svh"
module prc_top_bench;
   import prc_pkg::*;
   logic        sys_clk_i, rst_i, psel_i, penable_i, pwrite_i, choice, sync_n, pe, se, fe;
   logic [11:0] paddr_i;
   logic [31:0] pwdata_i, prdata_o, q;
   logic        pready_o, pslverr_o, pri, sec, fb, up, dn, hiz, dpw, ppw, spw, mon, st, sa;
   logic        pr, pf, cal, e;
   logic [2:0]  cur;
   int          err_total, cmp_count, r, f, nu, nd;
   prc_ref_src src (.pri_en_i(pe), .sec_en_i(se), .fb_en_i(fe), .primary_reference_o(pri),
      .secondary_reference_o(sec), .vco_feedback_o(fb));
   prc_top DUT (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .paddr_i(paddr_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
      .pready_o(pready_o), .pslverr_o(pslverr_o), .primary_reference_i(pri),
      .secondary_reference_i(sec), .vco_feedback_i(fb), .reference_choice_pin_i(choice),
      .sync_n_i(sync_n), .pump_up_o(up), .pump_down_o(dn), .pump_hiz_o(hiz),
      .pump_current_o(cur), .diff_rx_power_o(dpw), .primary_buf_power_o(ppw),
      .secondary_buf_power_o(spw), .reference_monitor_pin_o(mon), .status_pin_o(st),
      .secondary_active_o(sa), .pfd_ref_o(pr), .pfd_fb_o(pf), .vco_cal_o(cal));
   initial begin
      sys_clk_i = 1'b0;
      forever #4 sys_clk_i = ~sys_clk_i;
   end
   task automatic wrap_up;
      if (err_total == 0 && cmp_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : wrap_up
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
      int n;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= wr;
      paddr_i <= {idx, 2'b00};
      pwdata_i <= d;
      @(posedge sys_clk_i);
      penable_i <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk_i);
         n++;
      end while (pready_o !== 1'b1 && n < 20);
      if (pready_o !== 1'b1) begin
         err_total++;
         wrap_up();
      end
      q = prdata_o;
      e = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge sys_clk_i);
   endtask : apb
   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      apb(1'b1, idx, {24'h0, d});
   endtask : wr
   task automatic upd;
      wr(10'h232, 8'h01);
      repeat (4) @(posedge sys_clk_i);
   endtask : upd
   task automatic count(input int n);
      r = 0;
      f = 0;
      nu = 0;
      nd = 0;
      repeat (n) begin
         @(posedge sys_clk_i);
         r += int'(pr === 1'b1);
         f += int'(pf === 1'b1);
         nu += int'(up === 1'b1);
         nd += int'(dn === 1'b1);
      end
   endtask : count
   function automatic logic near(input int v, input int x);
      return v >= x - 1 && v <= x + 1;
   endfunction : near
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
      {choice, pe, se, fe} = '0;
      sync_n = 1'b1;
      rst_i = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      rst_i <= 1'b0;
      @(posedge sys_clk_i);
      check("reset outputs", {hiz, dpw, ppw, spw, up, dn}, 32'h20);
      apb(1'b0, 10'h3ff, 32'h0);
      check("unmapped error", e, 32'h1);
      {pe, se, fe} = 3'b111;
      wr(10'h010, 8'h30);
      wr(10'h01c, 8'h06);
      upd();
      check("single-ended power", {dpw, ppw, spw}, 32'h3);
      wr(10'h01c, 8'h07);
      wr(10'h01d, 8'h01);
      upd();
      check("diff power", {dpw, ppw, spw}, 32'h4);
      wr(10'h010, 8'h31);
      upd();
      check("loop down power", {dpw, ppw, spw}, 32'h0);
      for (int m = 0; m < 3; m++) begin
         wr(10'h010, 8'(m << 4));
         wr(10'h020, 8'(m + 5));
         upd();
         check("pump mode", {hiz, up, dn}, 32'h1 << (2 - m));
         check("pump current", cur, m + 5);
      end
      wr(10'h018, 8'h01);
      wr(10'h010, 8'h30);
      wr(10'h01c, 8'h06);
      upd();
      check("calibration", cal, 32'h1);
      apb(1'b0, 10'h01c, 32'h0);
      check("readback", q, 32'h06);
      wr(10'h016, 8'h00);
      wr(10'h015, 8'h00);
      for (int k = 0; k < 5; k++) begin
         wr(10'h011, 8'(k));
         upd();
         count(1200);
         check("ref divide", near(r, k < 2 ? 60 : 60 / k), 32'h1);
         if (k > 1) check("pump down leads", nd > nu, 32'h1);
      end
      wr(10'h011, 8'h00);
      wr(10'h012, 8'h01);
      upd();
      count(1200);
      check("ref high byte", r < 2, 32'h1);
      wr(10'h012, 8'h00);
      for (int p = 0; p < 2; p++) begin
         wr(10'h016, 8'(p));
         wr(10'h014, 8'(4 - p));
         wr(10'h013, 8'(2 - 2 * p));
         upd();
         count(1200);
         check("fb divide", near(f, 12 - 2 * p), 32'h1);
         check("pump up leads", nu > nd, 32'h1);
      end
      for (int i = 0; i < 3; i++) begin
         wr(10'h016, 8'(8'h10 << i));
         upd();
         count(1200);
         check("r divider held", i == 1 ? near(r, 60) : r == 0, 32'h1);
         check("n divider held", i == 0 ? near(f, 20) : f == 0, 32'h1);
      end
      wr(10'h016, 8'h00);
      upd();
      sync_n <= 1'b0;
      count(1200);
      check("sync pin off", near(r, 60), 32'h1);
      wr(10'h019, 8'h80);
      upd();
      count(1200);
      check("sync reset", r, 32'h0);
      sync_n <= 1'b1;
      wr(10'h01c, 8'h46);
      upd();
      check("manual register", sa, 32'h1);
      choice <= 1'b1;
      wr(10'h01c, 8'h26);
      upd();
      check("manual pin", sa, 32'h1);
      wr(10'h01b, 8'hf7);
      wr(10'h01c, 8'h1e);
      upd();
      count(100);
      check("prefer secondary", sa, 32'h1);
      wr(10'h01c, 8'h0e);
      upd();
      pe = 1'b0;
      count(1400);
      check("primary lost", {mon, st, sa}, 32'h7);
      pe = 1'b1;
      count(300);
      check("revert", {mon, st, sa}, 32'h0);
      apb(1'b0, 10'h021, 32'h0);
      check("status", q, 32'h0d);
      wrap_up();
   end
   initial begin
      #400000;
      err_total++;
      wrap_up();
   end
endmodule : prc_top_bench
